/* verilog/hop_pkg.sv */
// Package for the spread-spectrum packet framer and hop sequencer.
// Assumes a 32-bit AXI4-Lite register bus with word-aligned byte addresses.
package hop_pkg;
	// Register byte offsets
	localparam logic [5:0] MODEM_CONFIG_TWO_OFS     = 6'h00;
	localparam logic [5:0] TRANSMIT_CONFIG_ONE_OFS  = 6'h04;
	localparam logic [5:0] SYMBOL_TIMEOUT_UPPER_OFS = 6'h08;
	localparam logic [5:0] PREAMBLE_OFS             = 6'h0C;
	localparam logic [5:0] DWELL_OFS                = 6'h10;
	localparam logic [5:0] CHIP_DIV_OFS             = 6'h14;
	localparam logic [5:0] PAYLOAD_LEN_OFS          = 6'h18;
	localparam logic [5:0] COMMAND_OFS              = 6'h1C;
	localparam logic [5:0] STATUS_OFS               = 6'h20;
	localparam logic [5:0] AIRTIME_OFS              = 6'h24;

	// Field positions
	localparam int SF_LSB       = 4;
	localparam int CRC_ON_BIT   = 2;
	localparam int HOP_EN_BIT   = 0;
	localparam int CR_LSB       = 1;
	localparam int HDRLESS_BIT  = 0;
	localparam int CMD_TX_BIT   = 0;
	localparam int CMD_RX_BIT   = 1;
	localparam int CMD_STOP_BIT = 2;
	localparam int FLAG_BIT     = 8;
	localparam int STATE_LSB    = 16;

	// Reset values and limits
	localparam logic [3:0]  SF_RESET      = 4'h7;
	localparam logic [3:0]  SF_MIN        = 4'h6;
	localparam logic [3:0]  SF_MAX        = 4'hC;
	localparam logic [2:0]  CR_RESET      = 3'h1;
	localparam logic [2:0]  CR_MIN        = 3'h1;
	localparam logic [2:0]  CR_MAX        = 3'h4;
	localparam logic [2:0]  HEADER_CR     = 3'h4;
	localparam logic [15:0] PRE_RESET     = 16'h000C;
	localparam logic [15:0] PRE_MIN       = 16'h0006;
	localparam logic [19:0] PRE_OVERHEAD  = 20'h0_0004;
	localparam logic [19:0] HDR_SYMBOLS   = 20'h0_0008;
	localparam logic [15:0] CHIP_DIV_RESET = 16'h0000;
	localparam logic [7:0]  DWELL_RESET   = 8'h00;
	localparam logic [7:0]  PAYLOAD_RESET = 8'h01;
	localparam logic [15:0] IMPL_ADD      = 16'h0018;
	localparam logic [15:0] EXPL_ADD      = 16'h002C;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [6:0] {
		ST_IDLE   = 7'h01,
		ST_TX_PRE = 7'h02,
		ST_TX_HDR = 7'h04,
		ST_TX_PAY = 7'h08,
		ST_RX_SRCH = 7'h10,
		ST_RX_HDR = 7'h20,
		ST_RX_PAY = 7'h40
	} frame_state_e;
endpackage

/* verilog/spread_packet_hop_control.sv */
// Packet timing framer and frequency-hop sequencer with an AXI4-Lite register file.
// Assumes the demodulator reports preamble and header-check events as one-cycle pulses.
// Function
// R1 - symbol rate is bandwidth over two^exponent
// R2 - preamble length resets to twelve symbols
// R3 - preamble length 6..65535, plus four symbols
// R4 - receiver preamble programmed like transmitter's; receive path ignores the preamble count, waits on preamble_detected_i
// R5 - headerless bit lives in timeout register
// R6 - explicit header default, carries length/rate/crc
// R7 - header sent at 4/8, bad header dropped
// R8 - implicit mode: no header, matched settings
// R9 - exponent six forces implicit header mode
// R10 - payload rate from header or register
// R11 - preamble lasts length plus 4.25 symbols
// R12 - payload symbols follow printed airtime formula
// R13 - hop enable bit steers transmit and receive
// R14 - dwell equals symbol period times count
// R15 - transmission starts, preamble and header, channel 0
// R16 - each hop bumps index, raises flag
// R17 - host reprograms channel, clears flag writing one
// R18 - reception starts channel 0, hops after preamble
// R19 - bad header CRC returns to channel 0
// R20 - spreading exponent limited six to twelve
// R21 - coding rate index limited one to four
// R22 - flag sticks until cleared, rehop sets again
//
// Implementation choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module spread_packet_hop_control (
	input  wire logic        clk_i,
	input  wire logic        reset_i,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [5:0]  s_axi_awaddr,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	output logic [1:0]       s_axi_bresp,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	input  wire logic [5:0]  s_axi_araddr,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	input  wire logic        preamble_detected_i,
	input  wire logic        header_crc_ok_i,
	input  wire logic        header_crc_bad_i,
	input  wire logic [7:0]  rx_hdr_length_i,
	input  wire logic [2:0]  rx_hdr_rate_i,
	output logic             hop_request_irq_o,
	output logic [5:0]       current_hop_index_o,
	output logic             symbol_tick_o,
	output logic             tx_busy_o,
	output logic             rx_busy_o,
	output logic [2:0]       coding_rate_o,
	output logic [7:0]       tx_hdr_length_o,
	output logic [2:0]       tx_hdr_rate_o,
	output logic             tx_hdr_crc_o
);
	typedef struct packed {
		logic                  have_aw;
		logic [5:0]            aw_addr;
		logic                  have_w;
		logic [31:0]           w_data;
		logic [3:0]            w_strb;
		logic                  bvalid;
		logic [1:0]            bresp;
		logic                  rvalid;
		logic [31:0]           rdata;
		logic [1:0]            rresp;
		logic [3:0]            spread_exponent;
		logic                  crc_on;
		logic                  hop_enable;
		logic [2:0]            coding_rate_index;
		logic                  headerless_select;
		logic [15:0]           preamble_symbol_count;
		logic [7:0]            dwell_symbol_count;
		logic [15:0]           chip_div;
		logic [7:0]            payload_len;
		hop_pkg::frame_state_e state;
		logic [15:0]           div_cnt;
		logic [11:0]           chip_cnt;
		logic [1:0]            quarter;
		logic [19:0]           quarters_left;
		logic [7:0]            dwell_cnt;
		logic [5:0]            hop_idx;
		logic                  hop_flag;
		logic                  sym_tick;
		logic [2:0]            rate;
	} ctl_s;

	ctl_s ctl_r;
	ctl_s ctl_nxt;

	// Byte-lane merge of a write into a stored word
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
	                                      input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[8*i +: 8] = nw[8*i +: 8];
			end
		end
		return res;
	endfunction

	// Payload symbols, as printed: (8 + ceil((num - 4SF) / 4SF)) * (CR + 4); negative numerator is 0
	function automatic logic [19:0] payload_syms(input logic [7:0] len, input logic [3:0] sf,
	                                             input logic [2:0] cr, input logic expl);
		logic [15:0] num;
		logic [15:0] pos;
		logic [15:0] den;
		logic [15:0] q;
		num = {5'h00, len, 3'h0} + (expl ? hop_pkg::EXPL_ADD : hop_pkg::IMPL_ADD);
		den = {10'h000, sf, 2'h0};
		pos = (num > den) ? num - den : 16'h0000;
		q   = (pos + den - 16'h0001) / den;
		return 20'((20'(q) + 20'h0_0008) * (20'(cr) + 20'h0_0004));
	endfunction

	function automatic logic [3:0] clamp_sf(input logic [3:0] v);
		return (v < hop_pkg::SF_MIN) ? hop_pkg::SF_MIN : (v > hop_pkg::SF_MAX) ? hop_pkg::SF_MAX : v;
	endfunction

	function automatic logic [2:0] clamp_cr(input logic [2:0] v);
		return (v < hop_pkg::CR_MIN) ? hop_pkg::CR_MIN : (v > hop_pkg::CR_MAX) ? hop_pkg::CR_MAX : v;
	endfunction

	logic        eff_hdrless;
	logic [19:0] pre_quarters;
	logic [19:0] tx_pay_syms;
	logic [19:0] rx_pay_syms;
	logic [11:0] quarter_chips;
	logic        chip_tick;
	logic        q_tick;
	logic        s_tick;
	logic        hop_evt;
	logic        wr_fire;
	logic [31:0] wr_word;
	logic [31:0] rd_word;
	logic        rd_hit;

	// Exponent six has no header format at all
	assign eff_hdrless   = ctl_r.headerless_select || ctl_r.spread_exponent == hop_pkg::SF_MIN; // see R9
	// Preamble of n + 4 symbols plus a quarter symbol, counted in quarters
	assign pre_quarters  = 20'(((20'(ctl_r.preamble_symbol_count) + hop_pkg::PRE_OVERHEAD) << 2)
	                          + 20'h0_0001); // see R3 see R11
	assign tx_pay_syms   = payload_syms(ctl_r.payload_len, ctl_r.spread_exponent,
	                                    ctl_r.coding_rate_index, !eff_hdrless); // see R12
	assign rx_pay_syms   = payload_syms(eff_hdrless ? ctl_r.payload_len : rx_hdr_length_i,
	                                    ctl_r.spread_exponent,
	                                    eff_hdrless ? ctl_r.coding_rate_index : clamp_cr(rx_hdr_rate_i),
	                                    !eff_hdrless); // see R10
	// One chip per divided clock; 2^SF chips per symbol, quartered
	assign quarter_chips = 12'((13'h0001 << (ctl_r.spread_exponent - 4'h2)) - 13'h0001); // see R1
	assign chip_tick     = ctl_r.div_cnt == ctl_r.chip_div;
	assign q_tick        = chip_tick && ctl_r.chip_cnt == quarter_chips;
	assign s_tick        = q_tick && ctl_r.quarter == 2'h3;
	// Hops only in the payload phases, so preamble and header stay on channel 0
	assign hop_evt       = s_tick && ctl_r.hop_enable && ctl_r.dwell_symbol_count != 8'h00
	                       && (ctl_r.state == hop_pkg::ST_TX_PAY || ctl_r.state == hop_pkg::ST_RX_PAY)
	                       && ctl_r.dwell_cnt + 8'h01 == ctl_r.dwell_symbol_count; // see R13 see R14 see R15
	assign wr_fire       = ctl_r.have_aw && ctl_r.have_w && !ctl_r.bvalid;
	assign wr_word       = merge(32'h0000_0000, ctl_r.w_data, ctl_r.w_strb);

	always_comb begin
		rd_hit  = 1'b1;
		rd_word = 32'h0000_0000;
		case (s_axi_araddr)
			hop_pkg::MODEM_CONFIG_TWO_OFS: begin
				rd_word[hop_pkg::SF_LSB +: 4]   = ctl_r.spread_exponent;
				rd_word[hop_pkg::CRC_ON_BIT]    = ctl_r.crc_on;
			end
			hop_pkg::TRANSMIT_CONFIG_ONE_OFS: begin
				rd_word[hop_pkg::HOP_EN_BIT]    = ctl_r.hop_enable;
				rd_word[hop_pkg::CR_LSB +: 3]   = ctl_r.coding_rate_index;
			end
			hop_pkg::SYMBOL_TIMEOUT_UPPER_OFS: rd_word[hop_pkg::HDRLESS_BIT] = ctl_r.headerless_select;
			hop_pkg::PREAMBLE_OFS:     rd_word[15:0] = ctl_r.preamble_symbol_count;
			hop_pkg::DWELL_OFS:        rd_word[7:0]  = ctl_r.dwell_symbol_count;
			hop_pkg::CHIP_DIV_OFS:     rd_word[15:0] = ctl_r.chip_div;
			hop_pkg::PAYLOAD_LEN_OFS:  rd_word[7:0]  = ctl_r.payload_len;
			hop_pkg::COMMAND_OFS:      rd_word       = 32'h0000_0000;
			hop_pkg::STATUS_OFS: begin
				rd_word[5:0]                    = ctl_r.hop_idx;
				rd_word[hop_pkg::FLAG_BIT]      = ctl_r.hop_flag;
				rd_word[hop_pkg::STATE_LSB +: 7] = ctl_r.state;
			end
			hop_pkg::AIRTIME_OFS:      rd_word[19:0] = 20'(pre_quarters + (tx_pay_syms << 2));
			default:                   rd_hit        = 1'b0;
		endcase
	end

	always_comb begin
		ctl_nxt          = ctl_r;
		ctl_nxt.sym_tick = s_tick;

		// Address and data are taken independently, answer follows both
		if (s_axi_awvalid && !ctl_r.have_aw) begin
			ctl_nxt.have_aw = 1'b1;
			ctl_nxt.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !ctl_r.have_w) begin
			ctl_nxt.have_w = 1'b1;
			ctl_nxt.w_data = s_axi_wdata;
			ctl_nxt.w_strb = s_axi_wstrb;
		end
		if (s_axi_bvalid && s_axi_bready) begin
			ctl_nxt.bvalid = 1'b0;
		end
		if (s_axi_arvalid && !ctl_r.rvalid) begin
			ctl_nxt.rvalid = 1'b1;
			ctl_nxt.rdata  = rd_hit ? rd_word : 32'h0000_0000;
			ctl_nxt.rresp  = rd_hit ? hop_pkg::RESP_OKAY : hop_pkg::RESP_SLVERR;
		end else if (s_axi_rready) begin
			ctl_nxt.rvalid = 1'b0;
		end

		// Chip and symbol time base
		if (ctl_r.state != hop_pkg::ST_IDLE) begin
			ctl_nxt.div_cnt = chip_tick ? 16'h0000 : ctl_r.div_cnt + 16'h0001;
			if (chip_tick) begin
				ctl_nxt.chip_cnt = q_tick ? 12'h000 : ctl_r.chip_cnt + 12'h001;
			end
			if (q_tick) begin
				ctl_nxt.quarter       = ctl_r.quarter + 2'h1;
				ctl_nxt.quarters_left = ctl_r.quarters_left - 20'h0_0001;
			end
		end
		if (s_tick && (ctl_r.state == hop_pkg::ST_TX_PAY || ctl_r.state == hop_pkg::ST_RX_PAY)) begin
			ctl_nxt.dwell_cnt = hop_evt ? 8'h00 : ctl_r.dwell_cnt + 8'h01;
		end

		case (ctl_r.state)
			hop_pkg::ST_IDLE: begin
				ctl_nxt.hop_idx = 6'h00;
			end
			hop_pkg::ST_TX_PRE: begin
				if (q_tick && ctl_r.quarters_left == 20'h0_0001) begin
					ctl_nxt.quarter = 2'h0;
					if (eff_hdrless) begin // see R8
						ctl_nxt.state         = hop_pkg::ST_TX_PAY;
						ctl_nxt.quarters_left = 20'(tx_pay_syms << 2);
						ctl_nxt.rate          = ctl_r.coding_rate_index;
					end else begin
						ctl_nxt.state         = hop_pkg::ST_TX_HDR; // see R6
						ctl_nxt.quarters_left = hop_pkg::HDR_SYMBOLS << 2;
						ctl_nxt.rate          = hop_pkg::HEADER_CR; // see R7
					end
				end
			end
			hop_pkg::ST_TX_HDR: begin
				if (q_tick && ctl_r.quarters_left == 20'h0_0001) begin
					ctl_nxt.state         = hop_pkg::ST_TX_PAY;
					ctl_nxt.quarter       = 2'h0;
					ctl_nxt.quarters_left = 20'((tx_pay_syms - hop_pkg::HDR_SYMBOLS) << 2);
					ctl_nxt.rate          = ctl_r.coding_rate_index; // see R10
				end
			end
			hop_pkg::ST_RX_SRCH: begin
				// Waits on channel 0 for a preamble before any hopping
				if (preamble_detected_i) begin // see R18
					if (eff_hdrless) begin
						ctl_nxt.state         = hop_pkg::ST_RX_PAY;
						ctl_nxt.quarters_left = 20'(rx_pay_syms << 2);
						ctl_nxt.rate          = ctl_r.coding_rate_index;
					end else begin
						ctl_nxt.state = hop_pkg::ST_RX_HDR;
						ctl_nxt.rate  = hop_pkg::HEADER_CR;
					end
					ctl_nxt.quarter = 2'h0;
					ctl_nxt.div_cnt = 16'h0000;
					ctl_nxt.chip_cnt = 12'h000;
				end
			end
			hop_pkg::ST_RX_HDR: begin
				if (header_crc_bad_i) begin
					ctl_nxt.state   = hop_pkg::ST_RX_SRCH; // see R7 see R19
					ctl_nxt.hop_idx = 6'h00;
				end else if (header_crc_ok_i) begin
					ctl_nxt.state         = hop_pkg::ST_RX_PAY;
					ctl_nxt.quarter       = 2'h0;
					ctl_nxt.quarters_left = 20'((rx_pay_syms - hop_pkg::HDR_SYMBOLS) << 2);
					ctl_nxt.rate          = clamp_cr(rx_hdr_rate_i); // see R10
					ctl_nxt.dwell_cnt     = 8'h00;
				end
			end
			hop_pkg::ST_TX_PAY, hop_pkg::ST_RX_PAY: begin
				if (q_tick && ctl_r.quarters_left == 20'h0_0001) begin
					ctl_nxt.state = hop_pkg::ST_IDLE;
				end
			end
			default: ctl_nxt.state = hop_pkg::ST_IDLE;
		endcase

		if (hop_evt) begin
			ctl_nxt.hop_idx = ctl_r.hop_idx + 6'h01; // see R16
		end

		// Register writes; commands act only from idle, stop acts anywhere
		if (wr_fire) begin
			ctl_nxt.have_aw = 1'b0;
			ctl_nxt.have_w  = 1'b0;
			ctl_nxt.bvalid  = 1'b1;
			ctl_nxt.bresp   = hop_pkg::RESP_OKAY;
			case (ctl_r.aw_addr)
				hop_pkg::MODEM_CONFIG_TWO_OFS: if (ctl_r.w_strb[0]) begin
					ctl_nxt.spread_exponent = clamp_sf(wr_word[hop_pkg::SF_LSB +: 4]); // see R20
					ctl_nxt.crc_on          = wr_word[hop_pkg::CRC_ON_BIT];
				end
				hop_pkg::TRANSMIT_CONFIG_ONE_OFS: if (ctl_r.w_strb[0]) begin
					ctl_nxt.hop_enable        = wr_word[hop_pkg::HOP_EN_BIT]; // see R13
					ctl_nxt.coding_rate_index = clamp_cr(wr_word[hop_pkg::CR_LSB +: 3]); // see R21
				end
				hop_pkg::SYMBOL_TIMEOUT_UPPER_OFS: if (ctl_r.w_strb[0]) begin
					ctl_nxt.headerless_select = wr_word[hop_pkg::HDRLESS_BIT]; // see R5
				end
				hop_pkg::PREAMBLE_OFS: begin
					// Short values are raised to the minimum rather than refused
					ctl_nxt.preamble_symbol_count = merge({16'h0000, ctl_r.preamble_symbol_count},
					                                      ctl_r.w_data, ctl_r.w_strb) < 32'(hop_pkg::PRE_MIN)
					    ? hop_pkg::PRE_MIN
					    : 16'(merge({16'h0000, ctl_r.preamble_symbol_count}, ctl_r.w_data,
					                ctl_r.w_strb)); // see R3
				end
				hop_pkg::DWELL_OFS:
					ctl_nxt.dwell_symbol_count = ctl_r.w_strb[0] ? wr_word[7:0] : ctl_r.dwell_symbol_count;
				hop_pkg::CHIP_DIV_OFS:
					ctl_nxt.chip_div = 16'(merge({16'h0000, ctl_r.chip_div}, ctl_r.w_data, ctl_r.w_strb));
				hop_pkg::PAYLOAD_LEN_OFS:
					ctl_nxt.payload_len = ctl_r.w_strb[0] ? wr_word[7:0] : ctl_r.payload_len;
				hop_pkg::COMMAND_OFS: begin
					if (wr_word[hop_pkg::CMD_STOP_BIT]) begin
						ctl_nxt.state = hop_pkg::ST_IDLE;
					end else if (ctl_r.state == hop_pkg::ST_IDLE && wr_word[hop_pkg::CMD_TX_BIT]) begin
						ctl_nxt.state         = hop_pkg::ST_TX_PRE; // see R15
						ctl_nxt.quarters_left = pre_quarters;
						ctl_nxt.rate          = ctl_r.coding_rate_index;
					end else if (ctl_r.state == hop_pkg::ST_IDLE && wr_word[hop_pkg::CMD_RX_BIT]) begin
						ctl_nxt.state = hop_pkg::ST_RX_SRCH; // see R18
					end
					if (ctl_r.state == hop_pkg::ST_IDLE) begin
						ctl_nxt.hop_idx   = 6'h00;
						ctl_nxt.quarter   = 2'h0;
						ctl_nxt.div_cnt   = 16'h0000;
						ctl_nxt.chip_cnt  = 12'h000;
						ctl_nxt.dwell_cnt = 8'h00;
					end
				end
				hop_pkg::STATUS_OFS:
					if (ctl_r.w_strb[1] && wr_word[hop_pkg::FLAG_BIT]) begin
						ctl_nxt.hop_flag = 1'b0; // see R17
					end
				default: ctl_nxt.bresp = hop_pkg::RESP_SLVERR;
			endcase
		end
		// A hop in the clearing cycle keeps the flag set
		if (hop_evt) begin
			ctl_nxt.hop_flag = 1'b1; // see R16 see R22
		end
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			ctl_r                       <= '0;
			ctl_r.spread_exponent       <= hop_pkg::SF_RESET;
			ctl_r.coding_rate_index     <= hop_pkg::CR_RESET;
			ctl_r.preamble_symbol_count <= hop_pkg::PRE_RESET; // see R2
			ctl_r.dwell_symbol_count    <= hop_pkg::DWELL_RESET;
			ctl_r.chip_div              <= hop_pkg::CHIP_DIV_RESET;
			ctl_r.payload_len           <= hop_pkg::PAYLOAD_RESET;
			ctl_r.state                 <= hop_pkg::ST_IDLE;
			ctl_r.rate                  <= hop_pkg::CR_RESET;
		end else begin
			ctl_r <= ctl_nxt;
		end
	end

	assign s_axi_awready       = !ctl_r.have_aw;
	assign s_axi_wready        = !ctl_r.have_w;
	assign s_axi_bvalid        = ctl_r.bvalid;
	assign s_axi_bresp         = ctl_r.bresp;
	assign s_axi_arready       = !ctl_r.rvalid;
	assign s_axi_rvalid        = ctl_r.rvalid;
	assign s_axi_rdata         = ctl_r.rdata;
	assign s_axi_rresp         = ctl_r.rresp;
	assign hop_request_irq_o   = ctl_r.hop_flag;
	assign current_hop_index_o = ctl_r.hop_idx;
	assign symbol_tick_o       = ctl_r.sym_tick;
	assign tx_busy_o           = ctl_r.state == hop_pkg::ST_TX_PRE || ctl_r.state == hop_pkg::ST_TX_HDR
	                             || ctl_r.state == hop_pkg::ST_TX_PAY;
	assign rx_busy_o           = ctl_r.state == hop_pkg::ST_RX_SRCH || ctl_r.state == hop_pkg::ST_RX_HDR
	                             || ctl_r.state == hop_pkg::ST_RX_PAY;
	assign coding_rate_o       = ctl_r.rate;
	assign tx_hdr_length_o     = ctl_r.payload_len; // see R6
	assign tx_hdr_rate_o       = ctl_r.coding_rate_index;
	assign tx_hdr_crc_o        = ctl_r.crc_on;

	sequence tx_cmd_s;
		wr_fire && ctl_r.aw_addr == hop_pkg::COMMAND_OFS && ctl_r.w_strb[0] && ctl_r.w_data[0]
		&& !ctl_r.w_data[2] && ctl_r.state == hop_pkg::ST_IDLE;
	endsequence
	sequence pre_loaded_s;
		ctl_r.state == hop_pkg::ST_TX_PRE && ctl_r.hop_idx == 6'h00;
	endsequence

	tx_start_preamble_a: assert property (@(posedge clk_i) disable iff (reset_i) // see R11
		tx_cmd_s |=> pre_loaded_s ##0 ctl_r.quarters_left
		== 20'((20'(ctl_r.preamble_symbol_count) + 20'h0_0004) * 20'h0_0004 + 20'h0_0001))
		else $error("preamble length not loaded as n+4.25 symbols");
	hdr_channel_zero_a: assert property (@(posedge clk_i) disable iff (reset_i) // see R15
		(ctl_r.state inside {hop_pkg::ST_TX_PRE, hop_pkg::ST_TX_HDR, hop_pkg::ST_RX_SRCH,
		                     hop_pkg::ST_RX_HDR}) |-> ctl_r.hop_idx == 6'h00)
		else $error("preamble or header not on channel 0");
	hop_step_flag_a: assert property (@(posedge clk_i) disable iff (reset_i) // see R16
		hop_evt |=> hop_request_irq_o && current_hop_index_o == $past(current_hop_index_o) + 6'h01)
		else $error("hop did not bump index and raise flag");
	flag_sticks_a: assert property (@(posedge clk_i) disable iff (reset_i) // see R22
		hop_request_irq_o && !(wr_fire && ctl_r.aw_addr == hop_pkg::STATUS_OFS) |=> hop_request_irq_o)
		else $error("hop flag dropped without a clear");
	bad_header_return_a: assert property (@(posedge clk_i) disable iff (reset_i) // see R19
		ctl_r.state == hop_pkg::ST_RX_HDR && header_crc_bad_i && !wr_fire
		|=> ctl_r.state == hop_pkg::ST_RX_SRCH && current_hop_index_o == 6'h00)
		else $error("bad header did not return to channel 0 search");
	header_rate_a: assert property (@(posedge clk_i) disable iff (reset_i) // see R7
		ctl_r.state == hop_pkg::ST_TX_HDR |-> coding_rate_o == 3'h4)
		else $error("header not sent at 4/8");
	sf_six_implicit_a: assert property (@(posedge clk_i) disable iff (reset_i) // see R9
		ctl_r.spread_exponent == 4'h6 |-> eff_hdrless && ctl_r.state != hop_pkg::ST_TX_HDR)
		else $error("header mode used with exponent six");
	settings_range_a: assert property (@(posedge clk_i) disable iff (reset_i) // see R20 see R21 see R3
		ctl_r.spread_exponent inside {[4'h6:4'hC]} && ctl_r.coding_rate_index inside {[3'h1:3'h4]}
		&& ctl_r.preamble_symbol_count >= 16'h0006)
		else $error("setting out of range");
	dwell_spacing_a: assert property (@(posedge clk_i) disable iff (reset_i) // see R14
		hop_evt |-> ctl_r.dwell_cnt == ctl_r.dwell_symbol_count - 8'h01 && s_tick)
		else $error("hop not at dwell boundary");
	hop_gated_a: assert property (@(posedge clk_i) disable iff (reset_i) // see R13
		!ctl_r.hop_enable |=> $stable(current_hop_index_o) || ctl_r.hop_idx == 6'h00)
		else $error("hop while hopping disabled");
endmodule
`default_nettype wire

/* dv/demod_model.sv */
// Far-side model: demodulator events for the receive path.
// Assumes the block's clock and its active-high async reset.
`timescale 1ns/1ns
`default_nettype none
module demod_model (
	input  wire logic       clk_i,
	input  wire logic       reset_i,
	input  wire logic       rx_busy_i,
	input  wire logic       bad_hdr_i,
	output logic            pre_o,
	output logic            ok_o,
	output logic            bad_o,
	output logic [7:0]      len_o,
	output logic [2:0]      rate_o
);
	logic [4:0] cnt_r;
	// Fixed remote: length 1 and rate 4, whatever is set locally
	assign len_o = 8'h01;
	assign rate_o = 3'h4;
	// Events repeat, so whichever phase is waiting sees one
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			cnt_r <= 5'h00;
			{pre_o, ok_o, bad_o} <= 3'h0;
		end else begin
			cnt_r <= rx_busy_i ? cnt_r + 5'h01 : 5'h00;
			pre_o <= rx_busy_i && (&cnt_r);
			ok_o <= rx_busy_i && (&cnt_r) && !bad_hdr_i;
			bad_o <= rx_busy_i && (&cnt_r) && bad_hdr_i;
		end
	end
endmodule
`default_nettype wire

/* dv/tb_spread_packet_hop_control.sv */
// Bench for the hop framer: register reads and writes, hopped send, bad header.
// Assumes the framer's AXI4-Lite map and a demodulator model on the far side.
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
	$display("unexpected at %0t: got %h exp %h", $time, g, e); end end
module tb_spread_packet_hop_control;
	logic clk_i, reset_i, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, bad_sel;
	logic preamble_detected_i, header_crc_ok_i, header_crc_bad_i, hop_request_irq_o;
	logic symbol_tick_o, tx_busy_o, rx_busy_o, tx_hdr_crc_o;
	logic [5:0] s_axi_awaddr, s_axi_araddr, current_hop_index_o;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [7:0] rx_hdr_length_i, tx_hdr_length_o;
	logic [2:0] rx_hdr_rate_i, coding_rate_o, tx_hdr_rate_o;
	int n_mismatch, compares, i;
	spread_packet_hop_control dut_u (.*);
	demod_model far_u (.clk_i, .reset_i, .rx_busy_i(rx_busy_o), .bad_hdr_i(bad_sel),
		.pre_o(preamble_detected_i), .ok_o(header_crc_ok_i), .bad_o(header_crc_bad_i),
		.len_o(rx_hdr_length_i), .rate_o(rx_hdr_rate_i));
	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end
	task tally_and_finish();
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// Readies are sampled at the falling edge so the rising edge acts on settled values
	task wr(input logic [5:0] a, input logic [31:0] d);
		logic ra, rw, rb;
		@(posedge clk_i);
		{s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'h7};
		for (int k = 0; k < 100; k++) begin
			@(negedge clk_i);
			{ra, rw, rb} = {s_axi_awready, s_axi_wready, s_axi_bvalid};
			@(posedge clk_i);
			if (ra) s_axi_awvalid <= 1'b0;
			if (rw) s_axi_wvalid <= 1'b0;
			if (rb) begin
				s_axi_bready <= 1'b0;
				break;
			end
		end
	endtask
	task rd(input logic [5:0] a, input logic [31:0] e, input logic [1:0] er);
		logic ra, rv;
		logic [31:0] d;
		logic [1:0] r;
		@(posedge clk_i);
		{s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
		for (int k = 0; k < 100; k++) begin
			@(negedge clk_i);
			{ra, rv, d, r} = {s_axi_arready, s_axi_rvalid, s_axi_rdata, s_axi_rresp};
			@(posedge clk_i);
			if (ra) s_axi_arvalid <= 1'b0;
			if (rv) begin
				s_axi_rready <= 1'b0;
				`CHK(d, e)
				`CHK(r, er)
				break;
			end
		end
	endtask
	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, bad_sel} <= 6'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= 44'h000_0000_0000;
		s_axi_wstrb <= 4'hF;
		reset_i <= 1'b1;
		repeat (12) @(posedge clk_i);
		reset_i <= 1'b0;
		rd(hop_pkg::PREAMBLE_OFS, 32'h0000_000C, hop_pkg::RESP_OKAY);
		rd(hop_pkg::SYMBOL_TIMEOUT_UPPER_OFS, 32'h0000_0000, hop_pkg::RESP_OKAY);
		rd(6'h3C, 32'h0000_0000, hop_pkg::RESP_SLVERR);
		wr(hop_pkg::MODEM_CONFIG_TWO_OFS, 32'h0000_00F0);
		rd(hop_pkg::MODEM_CONFIG_TWO_OFS, 32'h0000_00C0, hop_pkg::RESP_OKAY);
		wr(hop_pkg::PREAMBLE_OFS, 32'h0000_0003);
		rd(hop_pkg::PREAMBLE_OFS, 32'h0000_0006, hop_pkg::RESP_OKAY);
		wr(hop_pkg::TRANSMIT_CONFIG_ONE_OFS, 32'h0000_000F);
		rd(hop_pkg::TRANSMIT_CONFIG_ONE_OFS, 32'h0000_0009, hop_pkg::RESP_OKAY);
		wr(hop_pkg::MODEM_CONFIG_TWO_OFS, 32'h0000_0060);
		wr(hop_pkg::DWELL_OFS, 32'h0000_0001);
		// Six plus 4.25 symbols, then 9 x 8 payload symbols, in quarter symbols
		rd(hop_pkg::AIRTIME_OFS, 32'h0000_0149, hop_pkg::RESP_OKAY);
		$display("test registers done");
		wr(hop_pkg::COMMAND_OFS, 32'h0000_0001);
		@(negedge clk_i);
		`CHK(current_hop_index_o, 6'h00)
		`CHK(tx_busy_o, 1'b1)
		`CHK({tx_hdr_length_o, tx_hdr_rate_o, tx_hdr_crc_o}, 12'h018)
		for (i = 0; i < 3000 && hop_request_irq_o !== 1'b1; i++) @(negedge clk_i);
		`CHK(current_hop_index_o, 6'h01)
		`CHK(symbol_tick_o, 1'b1)
		for (i = 0; i < 300 && current_hop_index_o !== 6'h02; i++) @(negedge clk_i);
		`CHK(hop_request_irq_o, 1'b1)
		wr(hop_pkg::STATUS_OFS, 32'h0000_0100);
		@(negedge clk_i);
		`CHK(hop_request_irq_o, 1'b0)
		wr(hop_pkg::COMMAND_OFS, 32'h0000_0004);
		$display("test hopped send done");
		bad_sel <= 1'b1;
		wr(hop_pkg::MODEM_CONFIG_TWO_OFS, 32'h0000_0070);
		wr(hop_pkg::COMMAND_OFS, 32'h0000_0002);
		repeat (2000) @(negedge clk_i);
		`CHK(current_hop_index_o, 6'h00)
		`CHK(rx_busy_o, 1'b1)
		$display("test bad header done");
		// Register rate 1 so the header's fixed 4/8 and the received rate 4 both stand apart from it
		wr(hop_pkg::COMMAND_OFS, 32'h0000_0004);
		bad_sel <= 1'b0;
		wr(hop_pkg::TRANSMIT_CONFIG_ONE_OFS, 32'h0000_0003);
		wr(hop_pkg::COMMAND_OFS, 32'h0000_0001);
		repeat (1500) @(negedge clk_i);
		`CHK(coding_rate_o, 3'h4)
		`CHK(current_hop_index_o, 6'h00)
		wr(hop_pkg::COMMAND_OFS, 32'h0000_0004);
		wr(hop_pkg::COMMAND_OFS, 32'h0000_0002);
		for (i = 0; i < 2000 && hop_request_irq_o !== 1'b1; i++) @(negedge clk_i);
		`CHK(current_hop_index_o, 6'h01)
		`CHK(coding_rate_o, 3'h4)
		$display("test header paths done");
		tally_and_finish();
	end
	initial begin
		#3000000;
		n_mismatch++;
		tally_and_finish();
	end
endmodule
`default_nettype wire
